/* File: shared/afe_sel_pkg.sv */
// Purpose: Shared constants and types for the selectable sensor front end
// Assumes: One mode register and two config registers behind an I2C slave
// Notes:   Reset values of the two config registers are plain defaults
`default_nettype none

package afe_sel_pkg;

    // ****************************************
    // Addressing and register map
    // ****************************************
    localparam logic [6:0] DEV_ADDR_DEF = 7'h48;  // Arbitrary bus address
    localparam logic [7:0] REG_CFG_A    = 8'h10;
    localparam logic [7:0] REG_CFG_B    = 8'h11;
    localparam logic [7:0] REG_MODE     = 8'h12;
    localparam logic [7:0] CFG_A_RST    = 8'h00;
    localparam logic [7:0] CFG_B_RST    = 8'h00;
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] PTR_RST      = 8'h00;
    localparam logic [7:0] MODE_WMASK   = 8'h87;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;
    localparam int         MODE_SHORT_BIT = 7;
    localparam logic [3:0] BIT_LAST     = 4'h7;

    // ****************************************
    // Operating mode codes
    // ****************************************
    localparam logic [2:0] MODE_DEEP_SLEEP     = 3'b000;
    localparam logic [2:0] MODE_TWO_LEAD       = 3'b001;
    localparam logic [2:0] MODE_STANDBY        = 3'b010;
    localparam logic [2:0] MODE_THREE_LEAD     = 3'b011;
    localparam logic [2:0] MODE_TEMP_STAGE_OFF = 3'b110;
    localparam logic [2:0] MODE_TEMP_STAGE_ON  = 3'b111;

    typedef enum logic [2:0] {
        PH_ADDR  = 3'b000,
        PH_PTR   = 3'b001,
        PH_WDATA = 3'b010,
        PH_RDATA = 3'b011,
        PH_IDLE  = 3'b100
    } phase_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic       ptr_en;
        logic       wr_en;
        logic [7:0] data;
    } cfg_wr_t;

    typedef struct packed {
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        logic [7:0] mode;
    } cfg_regs_t;

    typedef struct packed {
        logic control_amplifier;
        logic transimpedance_stage;
        logic temp_sensor;
        logic shorting_switch;
    } analog_en_t;

    localparam cfg_regs_t REGS_RST = '{cfg_a: CFG_A_RST, cfg_b: CFG_B_RST, mode: MODE_RST};

endpackage : afe_sel_pkg

`default_nettype wire

/* File: verilog/cfg_bank.sv */
// Purpose: Configuration registers and pointer, clocked by the bus clock
// Assumes: Write strobes come from the bit engine in the same domain
// Notes:   Toggle flips on every data write so the core can copy the words
`default_nettype none

module cfg_bank (
    // Link side
    input  wire logic                 scl_i,
    input  wire logic                 rstn_i,
    input  wire afe_sel_pkg::cfg_wr_t wr_i,
    // Contents
    output logic [7:0]                ptr_o,
    output afe_sel_pkg::cfg_regs_t    regs_o,
    output logic                      wr_tgl_o
);
    import afe_sel_pkg::*;

    typedef struct packed {
        cfg_regs_t  regs;
        logic [7:0] ptr;
        logic       tgl;
    } bank_t;

    localparam bank_t BANK_RST = '{regs: REGS_RST, ptr: PTR_RST, tgl: 1'b0};

    bank_t q;
    bank_t d;

    always_comb begin
        d = q;
        if (wr_i.ptr_en) begin
            d.ptr = wr_i.data;
        end
        if (wr_i.wr_en) begin
            case (q.ptr)
                REG_CFG_A: d.regs.cfg_a = wr_i.data;
                REG_CFG_B: d.regs.cfg_b = wr_i.data;
                REG_MODE:  d.regs.mode = wr_i.data & MODE_WMASK;  // R10 R11
                default:   d.regs = q.regs;
            endcase
            d.tgl = ~q.tgl;
        end
    end

    // Survives frame resets: pointer and settings outlive one transfer
    always_ff @(posedge scl_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= BANK_RST;
        end else begin
            q <= d;
        end
    end

    assign ptr_o    = q.ptr;
    assign regs_o   = q.regs;
    assign wr_tgl_o = q.tgl;

    mode_write_a: assert property ( // R11
        @(posedge scl_i) disable iff (!rstn_i)
        wr_i.wr_en && q.ptr == REG_MODE |=>
            q.regs.mode[6:3] == 4'h0 && q.regs.mode[2:0] == $past(wr_i.data[2:0]))
        else $error("mode write not stored with reserved bits cleared");

endmodule : cfg_bank

`default_nettype wire

/* File: verilog/sensor_select_afe.sv */
// Purpose: I2C slave with module select and mode-driven analog gating
// Assumes: Bus clock low phase spans at least four core clock cycles
// Notes:   Bit engine runs on the bus clock; core clock sees start and stop
`default_nettype none

// Contract
// (R1) Answer only on one fixed slave address, set at build time.
// (R2) Take part in bus traffic only while module select is low.
// (R3) Only the selected unit acknowledges; deselected units never drive.
// (R4) Host asserts exactly one select per transfer, then releases it; the host model also runs one transfer with none (unit N).
// (R5) Host loads configuration from EEPROM into registers 10h, 11h, 12h; the test writes fixed values there directly, with no EEPROM on the bus.
// (R6) Host uses only EEPROM addresses with lowest address bit zero.
// (R7) Within a selected module only one part acknowledges each command.
// (R8) Host may use standby or deep sleep between measurements.
// (R9) Mode gates amplifier, transimpedance stage and temperature sensor.
// (R10) Three-bit mode field, deep sleep after reset.
// (R11) Top mode bit enables shorting switch, off at reset; bits 6:3 reserved.
module sensor_select_afe #(
    parameter logic [6:0] DEV_ADDR = afe_sel_pkg::DEV_ADDR_DEF
) (
    // Core clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    // Bus pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    input  wire logic                 module_select_n_i,
    // Analog control
    output afe_sel_pkg::analog_en_t   an_o,
    output logic [2:0]                operating_mode_o,
    output logic [7:0]                cfg_a_o,
    output logic [7:0]                cfg_b_o
);
    import afe_sel_pkg::*;

    // ****************************************
    // Core clock domain
    // ****************************************
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] sel_s;
        logic [1:0] tgl_s;
        logic       scl_p;
        logic       sda_p;
        logic       tgl_p;
        logic       hold;
        logic       go;
        cfg_regs_t  regs;
        analog_en_t an;
    } core_t;

    localparam core_t CORE_RST = '{scl_s: 2'h3, sda_s: 2'h3, sel_s: 2'h3, tgl_s: 2'h0,
                                   scl_p: 1'b1, sda_p: 1'b1, tgl_p: 1'b0, hold: 1'b1,
                                   go: 1'b0, regs: REGS_RST, an: 4'h0};

    core_t      core_q;
    core_t      core_d;
    logic       bus_start;
    logic       bus_stop;
    logic       bank_tgl;
    cfg_regs_t  bank_regs;
    logic [7:0] bank_ptr;
    logic       eng_rst_n;

    function automatic analog_en_t decode_mode(input logic [7:0] mode);
        analog_en_t en;
        en = '0;
        case (mode[2:0])
            MODE_DEEP_SLEEP:   en = '0;
            MODE_TWO_LEAD:     en.transimpedance_stage = 1'b1;
            MODE_STANDBY:      en.control_amplifier = 1'b1;
            MODE_THREE_LEAD: begin
                en.control_amplifier = 1'b1;
                en.transimpedance_stage = 1'b1;
            end
            MODE_TEMP_STAGE_OFF: begin
                en.control_amplifier = 1'b1;
                en.temp_sensor = 1'b1;
            end
            MODE_TEMP_STAGE_ON: begin
                en.control_amplifier = 1'b1;
                en.temp_sensor = 1'b1;
                en.transimpedance_stage = 1'b1;
            end
            default:           en = '0;
        endcase
        en.shorting_switch = mode[MODE_SHORT_BIT];  // R11
        return en;
    endfunction : decode_mode

    // Edges judged on second stage and its delayed copy only
    assign bus_start = core_q.scl_s[1] && core_q.scl_p && core_q.sda_p && !core_q.sda_s[1];
    assign bus_stop  = core_q.scl_s[1] && core_q.scl_p && !core_q.sda_p && core_q.sda_s[1];

    always_comb begin
        core_d       = core_q;
        core_d.scl_s = {core_q.scl_s[0], scl_i};
        core_d.sda_s = {core_q.sda_s[0], sda_i};
        core_d.sel_s = {core_q.sel_s[0], module_select_n_i};
        core_d.tgl_s = {core_q.tgl_s[0], bank_tgl};
        core_d.scl_p = core_q.scl_s[1];
        core_d.sda_p = core_q.sda_s[1];
        core_d.tgl_p = core_q.tgl_s[1];
        // Engine sits in reset outside a selected frame
        if (core_q.sel_s[1] || bus_stop) begin  // R2 R3
            core_d.hold = 1'b1;
            core_d.go   = 1'b0;
        end else if (bus_start) begin  // R2
            core_d.hold = 1'b1;
            core_d.go   = 1'b1;
        end else if (core_q.go && !core_q.scl_s[1]) begin
            // Release while the bus clock is low, far from its next edge
            core_d.hold = 1'b0;
            core_d.go   = 1'b0;
        end
        // Bank words stand still for a whole byte after the toggle moves
        if (core_q.tgl_s[1] != core_q.tgl_p) begin
            core_d.regs = bank_regs;  // R10
        end
        core_d.an = decode_mode(core_q.regs.mode);  // R9
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_q <= CORE_RST;
        end else begin
            core_q <= core_d;
        end
    end

    assign eng_rst_n        = rstn_i & ~core_q.hold;
    assign an_o             = core_q.an;
    assign operating_mode_o = core_q.regs.mode[2:0];
    assign cfg_a_o          = core_q.regs.cfg_a;
    assign cfg_b_o          = core_q.regs.cfg_b;

    // ****************************************
    // Bus clock domain: bit engine
    // ****************************************
    typedef struct packed {
        phase_t     phase;
        logic [3:0] bitcnt;
        logic [6:0] shreg;
        logic       ack_slot;
        logic       ack;
        cfg_wr_t    wr;
    } eng_t;

    typedef struct packed {
        logic oe;
        logic sda;
    } drv_t;

    localparam eng_t ENG_RST = '{phase: PH_ADDR, bitcnt: 4'h0, shreg: 7'h00,
                                 ack_slot: 1'b0, ack: 1'b0, wr: '0};

    eng_t       eng_q;
    eng_t       eng_d;
    drv_t       drv_q;
    drv_t       drv_d;
    logic [7:0] byte_v;
    logic [7:0] rd_byte;

    always_comb begin
        eng_d           = eng_q;
        eng_d.wr.ptr_en = 1'b0;
        eng_d.wr.wr_en  = 1'b0;
        byte_v          = {eng_q.shreg, sda_i};
        if (eng_q.ack_slot) begin
            eng_d.ack_slot = 1'b0;
            eng_d.ack      = 1'b0;
            eng_d.bitcnt   = 4'h0;
            // Master refusal ends a read
            if (eng_q.phase == PH_RDATA && sda_i) begin
                eng_d.phase = PH_IDLE;
            end
        end else begin
            eng_d.shreg  = byte_v[6:0];
            eng_d.bitcnt = eng_q.bitcnt + 4'h1;
            if (eng_q.bitcnt == BIT_LAST) begin
                eng_d.ack_slot = 1'b1;
                case (eng_q.phase)
                    PH_ADDR: begin
                        if (eng_q.shreg == DEV_ADDR) begin  // R1
                            eng_d.ack   = 1'b1;
                            eng_d.phase = sda_i ? PH_RDATA : PH_PTR;
                        end else begin
                            eng_d.phase = PH_IDLE;
                        end
                    end
                    PH_PTR: begin
                        eng_d.ack       = 1'b1;
                        eng_d.wr.ptr_en = 1'b1;
                        eng_d.wr.data   = byte_v;
                        eng_d.phase     = PH_WDATA;
                    end
                    PH_WDATA: begin
                        eng_d.ack      = 1'b1;
                        eng_d.wr.wr_en = 1'b1;
                        eng_d.wr.data  = byte_v;
                    end
                    default: eng_d.ack = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge scl_i or negedge eng_rst_n) begin
        if (!eng_rst_n) begin
            eng_q <= ENG_RST;
        end else begin
            eng_q <= eng_d;
        end
    end

    always_comb begin
        case (bank_ptr)
            REG_CFG_A: rd_byte = bank_regs.cfg_a;
            REG_CFG_B: rd_byte = bank_regs.cfg_b;
            REG_MODE:  rd_byte = bank_regs.mode;
            default:   rd_byte = UNMAPPED_RD;
        endcase
        drv_d.sda = 1'b0;
        drv_d.oe  = 1'b0;
        if (eng_q.ack_slot) begin
            drv_d.oe = eng_q.ack;  // R3 R7
        end else if (eng_q.phase == PH_RDATA) begin
            drv_d.oe = ~rd_byte[~eng_q.bitcnt[2:0]];
        end
    end

    // Drive changes only while the bus clock is low
    always_ff @(negedge scl_i or negedge eng_rst_n) begin
        if (!eng_rst_n) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign sda_o    = drv_q.sda;
    assign sda_oe_o = drv_q.oe;

    cfg_bank u_bank (
        .scl_i    (scl_i),
        .rstn_i   (rstn_i),
        .wr_i     (eng_q.wr),
        .ptr_o    (bank_ptr),
        .regs_o   (bank_regs),
        .wr_tgl_o (bank_tgl)
    );

    // ****************************************
    // Checks
    // ****************************************
    sequence start_selected;
        bus_start && !core_q.sel_s[1];
    endsequence

    sequence release_point;
        core_q.go && !core_q.scl_s[1] && !core_q.sel_s[1] && !bus_stop;
    endsequence

    deselect_quiet_a: assert property ( // R3
        @(posedge mclk_i) disable iff (!rstn_i)
        core_q.sel_s[1] |-> ##2 !sda_oe_o)
        else $error("deselected unit still drives data line");

    start_arm_a: assert property ( // R2
        @(posedge mclk_i) disable iff (!rstn_i)
        start_selected |=> core_q.hold && core_q.go ##1 core_q.hold [*1])
        else $error("start did not arm the engine");

    frame_release_a: assert property ( // R2
        @(posedge mclk_i) disable iff (!rstn_i)
        release_point |=> !core_q.hold)
        else $error("engine not released in clock low phase");

    addr_miss_a: assert property ( // R1
        @(posedge scl_i) disable iff (!eng_rst_n)
        eng_q.phase == PH_ADDR && eng_q.bitcnt == BIT_LAST && !eng_q.ack_slot &&
            eng_q.shreg != DEV_ADDR |=> !eng_q.ack && eng_q.phase == PH_IDLE)
        else $error("foreign address acknowledged");

    ack_drive_a: assert property ( // R7
        @(posedge scl_i) disable iff (!eng_rst_n)
        eng_q.ack_slot && !$past(eng_q.ack_slot) |-> sda_oe_o == eng_q.ack)
        else $error("acknowledge slot drive mismatch");

    deep_sleep_a: assert property ( // R9
        @(posedge mclk_i) disable iff (!rstn_i)
        core_q.regs.mode[2:0] == MODE_DEEP_SLEEP |=>
            !an_o.control_amplifier && !an_o.transimpedance_stage && !an_o.temp_sensor)
        else $error("deep sleep left an analog block on");

    standby_gate_a: assert property ( // R9
        @(posedge mclk_i) disable iff (!rstn_i)
        core_q.regs.mode[2:0] == MODE_STANDBY |=>
            an_o.control_amplifier && !an_o.transimpedance_stage && !an_o.temp_sensor)
        else $error("standby gating wrong");

    amp_mode_a: assert property ( // R9
        @(posedge mclk_i) disable iff (!rstn_i)
        core_q.regs.mode[2:0] == MODE_THREE_LEAD |=>
            an_o.control_amplifier && an_o.transimpedance_stage && !an_o.temp_sensor)
        else $error("amperometric gating wrong");

    temp_mode_a: assert property ( // R9
        @(posedge mclk_i) disable iff (!rstn_i)
        core_q.regs.mode[2:1] == 2'b11 |=> an_o.control_amplifier && an_o.temp_sensor &&
            an_o.transimpedance_stage == $past(core_q.regs.mode[0]))
        else $error("temperature gating wrong");

    short_switch_a: assert property ( // R11
        @(posedge mclk_i) disable iff (!rstn_i)
        1'b1 |=> an_o.shorting_switch == $past(core_q.regs.mode[MODE_SHORT_BIT]))
        else $error("shorting switch does not follow mode bit");

    mode_copy_a: assert property ( // R10
        @(posedge mclk_i) disable iff (!rstn_i)
        core_q.tgl_s[1] == core_q.tgl_p |=> $stable(core_q.regs))
        else $error("settings changed without a write");

endmodule : sensor_select_afe

`default_nettype wire

/* File: verif/i2c_host_model.sv */
// Purpose: Bus master with one dedicated select line for each unit
// Assumes: Pull-ups on data and clock; all units share one bus address
// Notes:   Clock stands high between frames; unit index N selects none
`default_nettype none

module i2c_host_model #(
    parameter int N = 2
) (
    // Bus
    output logic         scl_o,
    output logic         sda_oe_o,
    input  wire logic    sda_i,
    // Selects
    output logic [N-1:0] sel_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quarter bit; slower than an 80 ns period, each phase needs four core cycles
    localparam int Q = 24;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
        sel_n_o = '1;
    end

    // ****************************************
    // Bit and frame primitives
    // ****************************************
    task automatic bit_cycle(input logic drv, output logic smp);
        scl_o = 1'b0;
        #Q;
        sda_oe_o = ~drv;
        #Q;
        scl_o = 1'b1;
        #Q;
        smp = sda_i;
        #Q;
    endtask : bit_cycle

    // Ack slot always released: write ack from unit, or master NACK on read
    task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(1'b1, nak);
    endtask : byte_xfer

    task automatic frame_start();
        scl_o = 1'b1;
        #Q;
        sda_oe_o = 1'b1;
        #(2*Q);
    endtask : frame_start

    task automatic frame_stop();
        scl_o = 1'b0;
        #Q;
        sda_oe_o = 1'b1;
        #Q;
        scl_o = 1'b1;
        #Q;
        sda_oe_o = 1'b0;
        #(2*Q);
    endtask : frame_stop

    // At most one select low per transfer (none for unit N), released before the next
    task automatic select(input int unit);
        if (unit < N) begin
            sel_n_o[unit] = 1'b0;
        end
        #203;
    endtask : select

    task automatic deselect();
        sel_n_o = '1;
        #203;
    endtask : deselect

    // ****************************************
    // Register access
    // ****************************************
    task automatic write_reg(input int unit, input logic [6:0] adr, input logic [7:0] ptr,
                             input logic [7:0] dat, output logic [2:0] naks);
        logic [7:0] rx;
        select(unit);
        frame_start();
        byte_xfer({adr, 1'b0}, rx, naks[2]);
        byte_xfer(ptr, rx, naks[1]);
        byte_xfer(dat, rx, naks[0]);
        frame_stop();
        deselect();
    endtask : write_reg

    task automatic read_reg(input int unit, input logic [6:0] adr, input logic [7:0] ptr,
                            output logic [7:0] dat, output logic [2:0] naks);
        logic nk;
        select(unit);
        frame_start();
        byte_xfer({adr, 1'b0}, dat, naks[2]);
        byte_xfer(ptr, dat, naks[1]);
        frame_stop();
        frame_start();
        byte_xfer({adr, 1'b1}, dat, naks[0]);
        byte_xfer(8'hff, dat, nk);
        frame_stop();
        deselect();
    endtask : read_reg

    // Master acknowledges the first data byte, so the unit sends a second one
    task automatic read_pair(input int unit, input logic [6:0] adr, output logic [7:0] d0,
                             output logic [7:0] d1);
        logic nk;
        select(unit);
        frame_start();
        byte_xfer({adr, 1'b1}, d0, nk);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d0[i]);
        end
        bit_cycle(1'b0, nk);
        byte_xfer(8'hff, d1, nk);
        frame_stop();
        deselect();
    endtask : read_pair

endmodule : i2c_host_model

`default_nettype wire

/* File: verif/sensor_select_afe_test.sv */
// Purpose: Two units sharing one bus, driven through the host model
// Assumes: Units built with the same default bus address
// Notes:   Distinct values per unit expose a unit taking part while deselected
`default_nettype none

module sensor_select_afe_test;
    timeunit 1ns;
    timeprecision 1ps;
    import afe_sel_pkg::*;

    localparam int         N      = 2;
    localparam logic [6:0] ADR    = DEV_ADDR_DEF;
    // Arbitrary memory address; its lowest hardware address bit stays low
    localparam logic [6:0] EE_ADR = 7'h50;

    logic             mclk_i = 1'b0;
    logic             rstn_i = 1'b0;
    wire logic        scl;
    wire logic        sda;
    logic             host_oe;
    logic [N-1:0]     sel_n;
    wire logic [N-1:0] dut_oe;
    wire logic [N-1:0] dut_o;
    analog_en_t       an [N];
    logic [2:0]       mode_o [N];
    logic [7:0]       cfg_a [N];
    logic [7:0]       cfg_b [N];
    int               errors = 0;
    int               n_tests = 0;

    always #5 mclk_i = ~mclk_i;

    // Open drain with pull-up: low if any party pulls
    assign sda = ~(host_oe | (|(dut_oe & ~dut_o)));

    i2c_host_model #(.N(N)) u_host (
        .scl_o    (scl),
        .sda_oe_o (host_oe),
        .sda_i    (sda),
        .sel_n_o  (sel_n)
    );

    for (genvar g = 0; g < N; g++) begin : g_unit
        sensor_select_afe u_dut (
            .mclk_i            (mclk_i),
            .rstn_i            (rstn_i),
            .scl_i             (scl),
            .sda_i             (sda),
            .sda_o             (dut_o[g]),
            .sda_oe_o          (dut_oe[g]),
            .module_select_n_i (sel_n[g]),
            .an_o              (an[g]),
            .operating_mode_o  (mode_o[g]),
            .cfg_a_o           (cfg_a[g]),
            .cfg_b_o           (cfg_b[g])
        );
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte

    task automatic complete_run();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Amplifier, transimpedance, temp sensor, shorting switch
    function automatic logic [3:0] exp_an(input logic [7:0] m);
        return {m[1], m[0] & ~(m[2] & ~m[1]), m[2] & m[1], m[7]};
    endfunction : exp_an

    initial begin
        #500us;
        errors++;
        complete_run();
    end

    initial begin
        logic [7:0] rd;
        logic [2:0] nk;
        logic [7:0] m;
        repeat (8) @(posedge mclk_i);
        #1 rstn_i = 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        for (int u = 0; u < N; u++) begin
            check_byte({5'h0, mode_o[u]}, {5'h0, MODE_DEEP_SLEEP});
            check_byte({4'h0, an[u]}, 8'h00);
            check_byte(cfg_a[u], CFG_A_RST);
        end
        // Startup load, one unit at a time
        for (int u = 0; u < N; u++) begin
            u_host.write_reg(u, ADR, REG_CFG_A, 8'h5a ^ 8'(u), nk);
            check_byte({5'h0, nk}, 8'h00);
            u_host.write_reg(u, ADR, REG_CFG_B, 8'ha5 ^ 8'(u), nk);
            u_host.write_reg(u, ADR, REG_MODE, {5'h0, MODE_STANDBY}, nk);
        end
        for (int u = 0; u < N; u++) begin
            check_byte(cfg_a[u], 8'h5a ^ 8'(u));
            check_byte(cfg_b[u], 8'ha5 ^ 8'(u));
            check_byte({5'h0, mode_o[u]}, {5'h0, MODE_STANDBY});
        end
        u_host.read_reg(0, ADR, REG_CFG_B, rd, nk);
        check_byte(rd, 8'ha5);
        check_byte({5'h0, nk}, 8'h00);
        // Master acknowledge: unit repeats the byte at the same pointer
        u_host.read_pair(0, ADR, rd, m);
        check_byte(rd, 8'ha5);
        check_byte(m, 8'ha5);
        u_host.write_reg(0, ADR ^ 7'h01, REG_CFG_A, 8'h11, nk);
        check_byte({5'h0, nk}, 8'h07);
        check_byte(cfg_a[0], 8'h5a);
        // No memory sits on this bus, so nothing answers this address, never the unit
        u_host.write_reg(0, EE_ADR, REG_CFG_A, 8'h33, nk);
        check_byte({5'h0, nk}, 8'h07);
        check_byte(cfg_a[0], 8'h5a);
        u_host.write_reg(N, ADR, REG_CFG_A, 8'h22, nk);
        check_byte({5'h0, nk}, 8'h07);
        check_byte(cfg_a[0], 8'h5a);
        check_byte(cfg_a[1], 8'h5b);
        for (int k = 0; k < 8; k++) begin
            m = {k[0], 4'hf, 3'(k)};
            u_host.write_reg(1, ADR, REG_MODE, m, nk);
            check_byte({5'h0, mode_o[1]}, {5'h0, 3'(k)});
            check_byte({4'h0, an[1]}, {4'h0, exp_an(m)});
            u_host.read_reg(1, ADR, REG_MODE, rd, nk);
            check_byte(rd, m & MODE_WMASK);
            check_byte({5'h0, mode_o[0]}, {5'h0, MODE_STANDBY});
        end
        u_host.write_reg(1, ADR, 8'h13, 8'h77, nk);
        check_byte({5'h0, nk}, 8'h00);
        check_byte(cfg_b[1], 8'ha4);
        u_host.read_reg(1, ADR, 8'h13, rd, nk);
        check_byte(rd, UNMAPPED_RD);
        u_host.write_reg(1, ADR, REG_MODE, {5'h0, MODE_DEEP_SLEEP}, nk);
        check_byte({4'h0, an[1]}, 8'h00);
        complete_run();
    end

endmodule : sensor_select_afe_test

`default_nettype wire
